/* rtl/uart_shadow_pkg.sv */
package uart_shadow_pkg;

   // =====================================================================
   // register map
   // =====================================================================
   localparam logic [31:0] ALIAS_BASE_ADDR  = 32'h5000_1130;
   localparam logic [31:0] SHADOW5_ADDR     = 32'h5000_1144;
   localparam logic [31:0] ALIAS_SPAN       = 32'h0000_0040;
   localparam logic [31:0] CTRL_ADDR        = 32'h5000_1180;
   localparam logic [31:0] STAT_ADDR        = 32'h5000_1184;
   localparam logic [31:0] APB_ZERO         = 32'h0000_0000;

   // =====================================================================
   // field layout
   // =====================================================================
   localparam int          BYTE_W           = 8;
   localparam int          CTRL_FIFO_EN_BIT = 0;
   localparam int          CTRL_IR_BIT      = 1;
   localparam int          STAT_DR_BIT      = 0;
   localparam int          STAT_OVR_BIT     = 1;
   localparam int          STAT_TXFULL_BIT  = 2;
   localparam int          STAT_RXFULL_BIT  = 3;
   localparam int          STAT_TX_HOLDING_EMPTY_FLAG_BIT    = 5;

   // =====================================================================
   // reset values and depths
   // =====================================================================
   localparam logic [7:0]  DATA_RESET       = 8'h00;
   localparam int          FIFO_DEPTH_DEF   = 16;
   localparam int          OUT_BUF_DEPTH    = 2;

endpackage : uart_shadow_pkg

/* rtl/uart_shadow_data_port.sv */
`timescale 1ns/100ps
`default_nettype none

module uart_shadow_data_port
   import uart_shadow_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH_DEF
) (
   // clock and reset
   input  wire  logic        core_clk_in,
   input  wire  logic        rst_n_in,
   // apb slave
   input  wire  logic        psel_in,
   input  wire  logic        penable_in,
   input  wire  logic        pwrite_in,
   input  wire  logic [31:0] paddr_in,
   input  wire  logic [31:0] pwdata_in,
   output logic       [31:0] prdata_out,
   output logic              pready_out,
   output logic              pslverr_out,
   // received bytes from the uart and infrared deserialisers
   input  wire  logic [7:0]  rx_uart_byte_in,
   input  wire  logic        rx_uart_valid_in,
   input  wire  logic [7:0]  rx_ir_byte_in,
   input  wire  logic        rx_ir_valid_in,
   // bytes to the serialiser
   output logic       [7:0]  tx_data_out,
   output logic              tx_valid_out,
   input  wire  logic        tx_ready_in,
   output logic              tx_ir_mode_out,
   // line status flags
   output logic              data_ready_flag_out,
   output logic              tx_holding_empty_flag_out,
   output logic              overrun_out
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
   localparam logic [CW-1:0] CNT_ONE  = CW'(1);
   localparam logic [CW-1:0] CNT_ZERO = CW'(0);
   localparam logic [AW-1:0] PTR_ONE  = AW'(1);
   localparam logic [AW-1:0] PTR_ZERO = AW'(0);
   localparam logic [1:0]    BUF_FULL = 2'(OUT_BUF_DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][BYTE_W-1:0] rx_mem;
      logic [AW-1:0]                rx_rd;
      logic [AW-1:0]                rx_wr;
      logic [CW-1:0]                rx_cnt;
      logic [DEPTH-1:0][BYTE_W-1:0] tx_mem;
      logic [AW-1:0]                tx_rd;
      logic [AW-1:0]                tx_wr;
      logic [CW-1:0]                tx_cnt;
      logic [1:0][BYTE_W-1:0]       obuf;
      logic [1:0]                   obuf_cnt;
      logic                         obuf_valid;
      logic                         fifo_en;
      logic                         ir_mode;
      logic                         overrun;
      logic                         dr;
      logic                         tx_holding_empty_flag;
      logic [31:0]                  prdata;
      logic                         pready;
      logic                         pslverr;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   // =====================================================================
   // combinational helpers
   // =====================================================================
   logic              access;
   logic [31:0]       alias_off;
   logic              hit_data;
   logic              hit_ctrl;
   logic              hit_stat;
   logic              rx_pop;
   logic              tx_push;
   logic              rx_ev;
   logic [7:0]        rx_byte;
   logic              rx_full;
   logic              tx_full;
   logic              drain;
   logic              obuf_pop;
   logic [7:0]        rx_head;
   logic [7:0]        tx_head;
   logic [7:0]        wbyte;
   logic [1:0]        bcnt;
   logic [31:0]       status_word;

   always_comb begin
      s_nxt       = s_r;
      access      = psel_in && penable_in && !s_r.pready;
      alias_off   = paddr_in - ALIAS_BASE_ADDR;
      hit_data    = (alias_off < ALIAS_SPAN) && (alias_off[1:0] == 2'h0);
      hit_ctrl    = (paddr_in == CTRL_ADDR);
      hit_stat    = (paddr_in == STAT_ADDR);
      rx_pop      = access && !pwrite_in && hit_data && (s_r.rx_cnt != CNT_ZERO);
      tx_push     = access && pwrite_in && hit_data;
      rx_ev       = s_r.ir_mode ? rx_ir_valid_in : rx_uart_valid_in;
      rx_byte     = s_r.ir_mode ? rx_ir_byte_in : rx_uart_byte_in;
      rx_full     = s_r.fifo_en ? (s_r.rx_cnt == CNT_FULL) : (s_r.rx_cnt == CNT_ONE);
      tx_full     = s_r.fifo_en ? (s_r.tx_cnt == CNT_FULL) : (s_r.tx_cnt == CNT_ONE);
      rx_head     = s_r.rx_mem[s_r.rx_rd];
      tx_head     = s_r.tx_mem[s_r.tx_rd];
      wbyte       = pwdata_in[BYTE_W-1:0];
      drain       = (s_r.tx_cnt != CNT_ZERO) && (s_r.obuf_cnt != BUF_FULL);
      obuf_pop    = s_r.obuf_valid && tx_ready_in;
      status_word = APB_ZERO;
      status_word[STAT_DR_BIT]     = s_r.dr;
      status_word[STAT_OVR_BIT]    = s_r.overrun;
      status_word[STAT_TXFULL_BIT] = tx_full;
      status_word[STAT_RXFULL_BIT] = rx_full;
      status_word[STAT_TX_HOLDING_EMPTY_FLAG_BIT]   = s_r.tx_holding_empty_flag;

      // ==================================================================
      // apb answer, one wait state
      // ==================================================================
      s_nxt.pready  = access;
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata  = APB_ZERO;
      if (access) begin
         if (!pwrite_in) begin
            if (hit_data) begin
               s_nxt.prdata[BYTE_W-1:0] = (s_r.rx_cnt != CNT_ZERO) ? rx_head : DATA_RESET;
            end else if (hit_ctrl) begin
               s_nxt.prdata[CTRL_FIFO_EN_BIT] = s_r.fifo_en;
               s_nxt.prdata[CTRL_IR_BIT]      = s_r.ir_mode;
            end else if (hit_stat) begin
               s_nxt.prdata = status_word;
            end else begin
               s_nxt.pslverr = 1'b1;
            end
         end else if (!(hit_data || hit_ctrl || hit_stat)) begin
            s_nxt.pslverr = 1'b1;
         end
      end

      // clear first, so an overrun raised in this cycle wins
      if (access && pwrite_in && hit_stat && pwdata_in[STAT_OVR_BIT]) begin
         s_nxt.overrun = 1'b0;
      end

      // ==================================================================
      // receive side
      // ==================================================================
      if (rx_pop) begin
         s_nxt.rx_rd  = s_r.fifo_en ? s_r.rx_rd + PTR_ONE : PTR_ZERO;
         s_nxt.rx_cnt = s_nxt.rx_cnt - CNT_ONE;
      end
      if (rx_ev) begin
         if (s_r.fifo_en) begin
            if (!rx_full || rx_pop) begin
               s_nxt.rx_mem[s_r.rx_wr] = rx_byte;
               s_nxt.rx_wr  = s_r.rx_wr + PTR_ONE;
               s_nxt.rx_cnt = s_nxt.rx_cnt + CNT_ONE;
            end else begin
               s_nxt.overrun = 1'b1;
            end
         end else begin
            s_nxt.rx_mem[PTR_ZERO] = rx_byte;
            s_nxt.rx_cnt           = CNT_ONE;
            if (rx_full && !rx_pop) begin
               s_nxt.overrun = 1'b1;
            end
         end
      end

      // ==================================================================
      // transmit side
      // ==================================================================
      if (drain) begin
         s_nxt.tx_rd  = s_r.fifo_en ? s_r.tx_rd + PTR_ONE : PTR_ZERO;
         s_nxt.tx_cnt = s_nxt.tx_cnt - CNT_ONE;
      end
      if (tx_push) begin
         if (s_r.fifo_en) begin
            if (!tx_full || drain) begin
               s_nxt.tx_mem[s_r.tx_wr] = wbyte;
               s_nxt.tx_wr  = s_r.tx_wr + PTR_ONE;
               s_nxt.tx_cnt = s_nxt.tx_cnt + CNT_ONE;
            end
         end else begin
            s_nxt.tx_mem[PTR_ZERO] = wbyte;
            s_nxt.tx_cnt           = CNT_ONE;
         end
      end

      // ==================================================================
      // two-entry output buffer towards the serialiser
      // ==================================================================
      bcnt = s_r.obuf_cnt;
      if (obuf_pop) begin
         s_nxt.obuf[0] = s_r.obuf[1];
         bcnt          = bcnt - 2'h1;
      end
      if (drain) begin
         // written byte heads for the line
         s_nxt.obuf[bcnt[0]] = tx_head;
         bcnt                = bcnt + 2'h1;
      end
      s_nxt.obuf_cnt   = bcnt;
      s_nxt.obuf_valid = (bcnt != 2'h0);

      // ==================================================================
      // control writes; the status overrun clear sits above
      // ==================================================================
      if (access && pwrite_in && hit_ctrl) begin
         s_nxt.ir_mode = pwdata_in[CTRL_IR_BIT];
         s_nxt.fifo_en = pwdata_in[CTRL_FIFO_EN_BIT];
         // switching fifo mode flushes both queues so pointers stay coherent
         if (pwdata_in[CTRL_FIFO_EN_BIT] != s_r.fifo_en) begin
            s_nxt.rx_rd  = PTR_ZERO;
            s_nxt.rx_wr  = PTR_ZERO;
            s_nxt.rx_cnt = CNT_ZERO;
            s_nxt.tx_rd  = PTR_ZERO;
            s_nxt.tx_wr  = PTR_ZERO;
            s_nxt.tx_cnt = CNT_ZERO;
         end
      end
      s_nxt.dr   = (s_nxt.rx_cnt != CNT_ZERO);
      s_nxt.tx_holding_empty_flag = (s_nxt.tx_cnt == CNT_ZERO);
   end

   // =====================================================================
   // state register
   // =====================================================================
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         s_r      <= '0;
         s_r.tx_holding_empty_flag <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata_out                = s_r.prdata;
   assign pready_out                = s_r.pready;
   assign pslverr_out               = s_r.pslverr;
   assign tx_data_out               = s_r.obuf[0];
   assign tx_valid_out              = s_r.obuf_valid;
   assign tx_ir_mode_out            = s_r.ir_mode;
   assign data_ready_flag_out       = s_r.dr;
   assign tx_holding_empty_flag_out = s_r.tx_holding_empty_flag;
   assign overrun_out               = s_r.overrun;

   // =====================================================================
   // assertions
   // =====================================================================
   apb_answer_a: assert property ( // apb timing
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (psel_in && penable_in && !pready_out) |=> (pready_out ##1 !pready_out))
      else $error("apb answer not a one-cycle pulse after one wait");

   read_head_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      rx_pop |=> (prdata_out[BYTE_W-1:0] == $past(rx_head)))
      else $error("data read did not return receive head");

   reserved_zero_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (access && !pwrite_in && hit_data) |=> (prdata_out[31:BYTE_W] == 24'h000000))
      else $error("reserved data bits not zero");

   nofifo_overrun_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (!s_r.fifo_en && rx_ev && rx_full && !rx_pop && !(access && pwrite_in))
      |=> (overrun_out && (s_r.rx_mem[0] == $past(rx_byte)) && data_ready_flag_out))
      else $error("unread byte not overwritten with overrun");

   rx_full_keep_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (s_r.fifo_en && rx_ev && rx_full && !rx_pop && !(access && pwrite_in))
      |=> (overrun_out && $stable(s_r.rx_mem) && (s_r.rx_cnt == CNT_FULL)))
      else $error("full receive fifo lost stored data");

   tx_holding_empty_flag_clear_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (!s_r.fifo_en && tx_push) |=> !tx_holding_empty_flag_out)
      else $error("holding empty still set after write");

   tx_accept_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (s_r.fifo_en && tx_push && !tx_full && !drain && !hit_ctrl)
      |=> (s_r.tx_cnt == $past(s_r.tx_cnt) + CNT_ONE))
      else $error("fifo write not accepted");

   tx_full_drop_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (s_r.fifo_en && tx_push && tx_full && !drain) |=> $stable(s_r.tx_mem))
      else $error("write into full transmit fifo stored");

   obuf_hold_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (tx_valid_out && !tx_ready_in) |=> (tx_valid_out && $stable(tx_data_out)))
      else $error("output byte changed while stalled");

   hold_overwrite_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (!s_r.fifo_en && tx_push) |=> (s_r.tx_mem[0] == $past(pwdata_in[BYTE_W-1:0])))
      else $error("held byte not replaced by write");

   rx_head_keep_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (s_r.fifo_en && rx_ev && !rx_pop && (s_r.rx_cnt != CNT_ZERO) && !(access && pwrite_in))
      |=> (rx_head == $past(rx_head)))
      else $error("new byte displaced receive head");

   rx_ready_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (rx_ev && !(access && pwrite_in)) |=> data_ready_flag_out)
      else $error("data ready not raised on arrival");

endmodule : uart_shadow_data_port

`default_nettype wire

/* verif/remote_link_model.sv */
`timescale 1ns/100ps
`default_nettype none
module remote_link_model (
   // clock and reset
   input  wire  logic       core_clk_in,
   input  wire  logic       rst_n_in,
   // bench control
   input  wire  logic       stall_in,
   input  wire  logic       fast_in,
   // bytes towards the port
   output logic       [7:0] rx_uart_byte_out,
   output logic             rx_uart_valid_out,
   output logic       [7:0] rx_ir_byte_out,
   output logic             rx_ir_valid_out,
   // bytes from the port
   input  wire  logic [7:0] tx_data_in,
   input  wire  logic       tx_valid_in,
   output logic             tx_ready_out
);
   int         seed = 32'hAA70;
   logic [7:0] got_q[$];
   initial begin
      {rx_uart_valid_out, rx_ir_valid_out, tx_ready_out} = 3'h0;
      {rx_uart_byte_out, rx_ir_byte_out} = 16'hA55A;
   end
   // byte lines show the inverse once released, never a stale byte
   task automatic send(input logic [7:0] b, input logic ir);
      if (ir) begin
         rx_ir_valid_out <= 1'b1;
         rx_ir_byte_out  <= b;
      end else begin
         rx_uart_valid_out <= 1'b1;
         rx_uart_byte_out  <= b;
      end
      @(posedge core_clk_in);
      {rx_uart_valid_out, rx_ir_valid_out} <= 2'h0;
      if (ir) rx_ir_byte_out <= ~b;
      else rx_uart_byte_out <= ~b;
      // idle edge: flags settle, next pulse never overlaps
      @(posedge core_clk_in);
   endtask : send
   // slow mode answers on random cycles
   always @(posedge core_clk_in) begin
      if (tx_valid_in && tx_ready_out) got_q.push_back(tx_data_in);
      tx_ready_out <= rst_n_in && !stall_in && (fast_in || 1'($random(seed)));
   end
endmodule : remote_link_model
`default_nettype wire

/* verif/tb_uart_shadow_data_port.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_uart_shadow_data_port
   import uart_shadow_pkg::*;
;
   localparam int D = 4;
   logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, stall = 0, fast = 1;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
   logic        pready, pslverr, err, txv, txr, irm, drf, tx_holding_empty_flag, ovr, uv, iv;
   logic [7:0]  txd, ub, ib, b;
   logic [7:0]  q[$];
   int          n_mismatch = 0, checks_done = 0, seed = 32'hAA70, i;
   always #4 clk = ~clk;
   uart_shadow_data_port #(.DEPTH(D)) u_uart_shadow_data_port (
      .core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .rx_uart_byte_in(ub),
      .rx_uart_valid_in(uv), .rx_ir_byte_in(ib), .rx_ir_valid_in(iv),
      .tx_data_out(txd), .tx_valid_out(txv), .tx_ready_in(txr), .tx_ir_mode_out(irm),
      .data_ready_flag_out(drf), .tx_holding_empty_flag_out(tx_holding_empty_flag), .overrun_out(ovr));
   remote_link_model u_remote_link_model (
      .core_clk_in(clk), .rst_n_in(rst_n), .stall_in(stall), .fast_in(fast),
      .rx_uart_byte_out(ub), .rx_uart_valid_out(uv), .rx_ir_byte_out(ib),
      .rx_ir_valid_out(iv), .tx_data_in(txd), .tx_valid_in(txv), .tx_ready_out(txr));
   // =====================================================================
   // helpers
   // =====================================================================
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
      checks_done++;
      if (g !== x) begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, x);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      // idle edge keeps the release and the next setup apart
      @(posedge clk);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd  = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
      if (n >= 20) begin
         n_mismatch++;
         final_report();
      end
   endtask : apb
   task automatic rdc(input logic [31:0] a, input logic [31:0] x, input string m);
      apb(1'b0, a, 32'h0);
      chk(rd, x, m);
      chk(32'(err), 32'h0, m);
   endtask : rdc
   // serialiser has drained when holding empty and nothing offered
   task automatic drain_cmp(input string m);
      int n;
      n = 0;
      while (!(tx_holding_empty_flag === 1'b1 && txv === 1'b0) && n < 400) begin
         @(posedge clk);
         n++;
      end
      if (n >= 400) begin
         n_mismatch++;
         final_report();
      end
      chk(32'(u_remote_link_model.got_q.size()), 32'(q.size()), m);
      foreach (q[k]) chk(32'(u_remote_link_model.got_q[k]), 32'(q[k]), m);
      u_remote_link_model.got_q.delete();
      q.delete();
   endtask : drain_cmp
   // =====================================================================
   // scenarios
   // =====================================================================
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(32'({drf, ovr, txv, tx_holding_empty_flag}), 32'h1, "reset flags");
      rdc(STAT_ADDR, 32'h20, "reset status");
      rdc(SHADOW5_ADDR, APB_ZERO, "empty read");
      apb(1'b0, 32'h5000_1100, 32'h0);
      chk(32'(err), 32'h1, "unmapped");
      $display("test reset done");
      b = 8'($random(seed));
      u_remote_link_model.send(b, 1'b0);
      chk(32'(drf), 32'h1, "ready flag");
      rdc(SHADOW5_ADDR, {24'h0, b}, "rx byte");
      u_remote_link_model.send(8'($random(seed)), 1'b0);
      b = 8'($random(seed));
      u_remote_link_model.send(b, 1'b0);
      chk(32'(ovr), 32'h1, "overrun");
      rdc(SHADOW5_ADDR, {24'h0, b}, "overwritten byte");
      apb(1'b1, STAT_ADDR, 32'h2);
      $display("test plain rx done");
      for (i = 0; i < 16; i++) begin
         apb(1'b1, CTRL_ADDR, 32'(i[0]) << CTRL_IR_BIT);
         chk(32'(irm), 32'(i[0]), "ir mode");
         b = 8'($random(seed));
         u_remote_link_model.send(b, i[0]);
         rdc(ALIAS_BASE_ADDR + 32'(4 * i), {24'h0, b}, "alias read");
      end
      $display("test aliases done");
      apb(1'b1, CTRL_ADDR, 32'h1);
      for (i = 0; i <= D; i++) begin
         b = 8'($random(seed));
         u_remote_link_model.send(b, 1'b0);
         if (i < D) q.push_back(b);
      end
      chk(32'(ovr), 32'h1, "fifo overrun");
      foreach (q[k]) rdc(SHADOW5_ADDR, {24'h0, q[k]}, "fifo order");
      chk(32'(drf), 32'h0, "fifo empty");
      q.delete();
      apb(1'b1, STAT_ADDR, 32'h2);
      $display("test rx fifo done");
      stall <= 1'b1;
      for (i = 0; i < D + 4; i++) begin
         b = 8'($random(seed));
         apb(1'b1, SHADOW5_ADDR, {24'($random(seed)), b});
         if (i < D + 2) q.push_back(b);
      end
      apb(1'b0, STAT_ADDR, 32'h0);
      chk(32'(rd[STAT_TXFULL_BIT]), 32'h1, "tx full");
      stall <= 1'b0;
      fast  <= 1'b0;
      drain_cmp("tx fifo");
      $display("test tx fifo done");
      apb(1'b1, CTRL_ADDR, 32'h0);
      stall <= 1'b1;
      fast  <= 1'b1;
      chk(32'(tx_holding_empty_flag), 32'h1, "holding empty");
      for (i = 0; i < 4; i++) begin
         b = 8'($random(seed));
         apb(1'b1, SHADOW5_ADDR, {24'h0, b});
         if (i != 2) q.push_back(b);
      end
      chk(32'(tx_holding_empty_flag), 32'h0, "holding full");
      stall <= 1'b0;
      drain_cmp("tx overwrite");
      $display("test tx plain done");
      final_report();
   end
endmodule : tb_uart_shadow_data_port
`default_nettype wire
